// *** rtl/sfs_pkg.sv ***
/*
 Shared constants, states and carriers of the standby and fail-safe
 supervisor. Assumes a 10 MHz system clock and an 8-bit core rail code.
*/
package sfs_pkg;
   // Register offsets
   localparam logic [7:0] SFS_REG_DYN_CTRL1 = 8'h36;
   localparam logic [7:0] SFS_REG_TREE_EN = 8'h6f;
   // Field positions
   localparam int SFS_CORE_LOW_GATE_POS = 1;
   localparam int SFS_TREE_BIT_POS = 0;
   // Reset values
   localparam logic [7:0] SFS_DYN_CTRL1_RST = 8'h00;
   localparam logic [7:0] SFS_TREE_EN_RST = 8'h00;
   localparam logic [7:0] SFS_TURN_ON_TEMP_RST = 8'h5a;
   localparam logic [15:0] SFS_OVERTEMP_TIME_RST = 16'h0000;
   // Timing
   localparam int SFS_CLK_HZ = 10_000_000;
   localparam int SFS_FAILSAFE_MS = 4600;
   localparam int SFS_FAILSAFE_CYC = SFS_CLK_HZ / 1000 * SFS_FAILSAFE_MS;
   // Power-up threshold of the core rail, and the converter's full scale
   localparam int SFS_RAIL_UP_MV = 750;
   localparam int SFS_RAIL_FULL_SCALE_MV = 3000;
   localparam logic [7:0] SFS_RAIL_UP_CODE =
      8'(SFS_RAIL_UP_MV * 256 / SFS_RAIL_FULL_SCALE_MV);
   // Counts of channels, outputs and fans
   localparam int SFS_NUM_CHAN = 3;
   localparam int SFS_NUM_PWM = 3;
   localparam int SFS_NUM_FANS = 4;

   // Power-on supervisor states
   typedef enum logic [4:0] {
      SFS_ST_POLL = 5'b00001,
      SFS_ST_WAIT_LOW = 5'b00010,
      SFS_ST_COUNT = 5'b00100,
      SFS_ST_FULL = 5'b01000,
      SFS_ST_NORMAL = 5'b10000
   } sfs_state_t;

   // Fan-specific settings of one drive output
   typedef struct packed {
      logic output_polarity_bit;
      logic [1:0] chan_sel;
      logic [7:0] min_duty;
      logic [3:0] ramp_step;
   } sfs_out_cfg_t;
endpackage

// *** rtl/sfs_sync.sv ***
/*
 Two-stage synchroniser for a bus of independent levels.
 Assumes each bit changes slowly compared with the destination clock.
*/
`timescale 1ns/10ps
module sfs_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Levels in and out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg; // First stage, read only by o_sync

   // Only the second stage is visible to any logic
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule

// *** rtl/sfs_pwm_channel.sv ***
/*
 One fan drive output: picks a temperature channel's demand, floors it at
 the minimum duty, ramps toward it and generates the pulse train.
 Assumes the channel demands are already calibrated per temperature channel.
*/
`timescale 1ns/10ps
module sfs_pwm_channel (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Settings and demands
   input wire sfs_pkg::sfs_out_cfg_t i_cfg,
   input wire logic [7:0] i_chan_duty [sfs_pkg::SFS_NUM_CHAN],
   input wire logic i_run,
   // Drive
   output logic o_active,
   output logic [7:0] o_duty
);
   logic [7:0] cnt_reg;    // Free running period counter
   logic [7:0] target;     // Floored demand
   logic [7:0] sel_duty;   // Demand of the chosen channel
   logic [8:0] up_sum;
   logic [8:0] dn_diff;

   // Channel choice and minimum duty floor
   always_comb begin
      sel_duty = 8'h00;
      if (i_cfg.chan_sel < 2'(sfs_pkg::SFS_NUM_CHAN)) begin
         sel_duty = i_chan_duty[i_cfg.chan_sel];
      end
      target = (sel_duty < i_cfg.min_duty) ? i_cfg.min_duty : sel_duty;
      up_sum = {1'b0, o_duty} + {5'h00, i_cfg.ramp_step};
      dn_diff = {1'b0, o_duty} - {5'h00, i_cfg.ramp_step};
   end

   // Period counter
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // Duty moves once per period, so the fan sees gentle changes
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_duty <= 8'h00;
      end else if (!i_run) begin
         o_duty <= 8'h00;
      end else if (cnt_reg == 8'hff) begin
         if (i_cfg.ramp_step == 4'h0) begin
            o_duty <= target; // Step of zero means no ramping
         end else if (o_duty < target) begin
            o_duty <= (up_sum[8] || up_sum[7:0] > target) ? target
                      : up_sum[7:0];
         end else if (o_duty > target) begin
            o_duty <= (dn_diff[8] || dn_diff[7:0] < target) ? target
                      : dn_diff[7:0];
         end
      end
   end

   // Active part of the period, polarity applied by the caller
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_active <= 1'b0;
      end else begin
         o_active <= i_run && (cnt_reg < o_duty);
      end
   end
endmodule

// *** rtl/sfs_supervisor.sv ***
/*
 Standby and fail-safe supervisor of a fan and thermal controller: core
 rail low gating, power-on fail-safe timer, board-test tree mode and the
 three fan drive outputs with four speed monitors.
 Assumes a register front end on the system clock, a core rail converter
 giving one result per valid pulse, and a bus front end on its own link
 clock that pulses once per valid transaction addressing this device.
*/
`timescale 1ns/10ps
module sfs_supervisor #(
   parameter int FAILSAFE_CYC = sfs_pkg::SFS_FAILSAFE_CYC,
   parameter int TREE_PINS = 8
) (
   // System clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Bus front end on the link clock
   input wire logic i_link_clk,
   input wire logic i_link_addr_match,
   // Register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Core rail conversion
   input wire logic i_rail_valid,
   input wire logic [7:0] i_cpu_core_rail_input,
   input wire logic [7:0] i_core_low_limit,
   // Status and alert
   input wire logic i_status_clear,
   input wire logic i_alert_en,
   output logic o_status_core_low,
   output logic o_smbalert_n,
   // Overtemperature pin and timer
   input wire logic i_overtemp_pin_n,
   output logic o_overtemp_watch,
   output logic [15:0] o_overtemp_time,
   // Fan turn-on temperature adjustment
   input wire logic i_fan_turn_on_temp_adj_valid,
   input wire logic [7:0] i_fan_turn_on_temp_adj_value,
   output logic [7:0] o_fan_turn_on_temp,
   // Shutdown
   input wire logic i_shutdown_req,
   output logic o_shutdown,
   // Temperature channels, already calibrated, and drive settings
   input wire logic [7:0] i_chan_duty [sfs_pkg::SFS_NUM_CHAN],
   input wire sfs_pkg::sfs_out_cfg_t i_out_cfg [sfs_pkg::SFS_NUM_PWM],
   // Fan speed monitors
   input wire logic [15:0] i_tach_count [sfs_pkg::SFS_NUM_FANS],
   input wire logic [15:0] i_tach_limit [sfs_pkg::SFS_NUM_FANS],
   output logic [sfs_pkg::SFS_NUM_FANS-1:0] o_fan_fail,
   // Tree test pins
   input wire logic [TREE_PINS-1:0] i_tree_pins,
   output logic o_tree_out,
   // Fan drive and power-on state
   output logic [sfs_pkg::SFS_NUM_PWM-1:0] o_pwm,
   output logic [sfs_pkg::SFS_NUM_PWM*8-1:0] o_duty,
   output logic o_fans_full,
   output logic o_load_defaults,
   output logic o_normal
);
   localparam int CW = $clog2(FAILSAFE_CYC + 1);
   localparam logic [CW-1:0] FS_LOAD = CW'(FAILSAFE_CYC - 1);

   // Refuse settings the logic cannot serve
   if (FAILSAFE_CYC < 2 || TREE_PINS < 2) begin : g_bad_param
      $error("sfs_supervisor: bad parameter");
   end

   sfs_pkg::sfs_state_t state_reg; // Power-on supervisor state
   logic [CW-1:0] fs_cnt_reg;      // Fail-safe countdown
   logic [7:0] dyn_ctrl1_reg;      // Offset 0x36
   logic [7:0] tree_en_reg;        // Offset 0x6f
   logic core_low_reg;             // Gated rail currently low
   logic link_tgl_reg;             // Link side event toggle
   logic tgl_sync;                 // Toggle after two stages
   logic tgl_seen_reg;             // Last toggle level taken
   logic addr_hit;                 // One pulse per addressing transaction
   logic overtemp_n_sync;          // Pin after two stages
   logic core_low_gate;
   logic tree_test_bit;
   logic tree_xnor;
   logic [sfs_pkg::SFS_NUM_PWM-1:0] ch_active;

   assign core_low_gate = dyn_ctrl1_reg[sfs_pkg::SFS_CORE_LOW_GATE_POS];
   assign tree_test_bit = tree_en_reg[sfs_pkg::SFS_TREE_BIT_POS];

   // Link domain: every addressing pulse flips a level
   always_ff @(posedge i_link_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         link_tgl_reg <= 1'b0;
      end else if (i_link_addr_match) begin
         link_tgl_reg <= ~link_tgl_reg;
      end
   end

   // Toggle crossing; the edge detect reads only the second stage
   sfs_sync #(.WIDTH(2)) u_sync (
      .i_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_async({link_tgl_reg, i_overtemp_pin_n}),
      .o_sync({tgl_sync, overtemp_n_sync})
   );

   // Recover the event pulse in the system domain
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_seen_reg <= tgl_sync;
      end
   end
   assign addr_hit = tgl_sync ^ tgl_seen_reg;

   // Register writes; defaults return when the device takes up its role
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dyn_ctrl1_reg <= sfs_pkg::SFS_DYN_CTRL1_RST;
         tree_en_reg <= sfs_pkg::SFS_TREE_EN_RST;
      end else if (o_load_defaults) begin
         dyn_ctrl1_reg <= sfs_pkg::SFS_DYN_CTRL1_RST;
         tree_en_reg <= sfs_pkg::SFS_TREE_EN_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == sfs_pkg::SFS_REG_DYN_CTRL1) begin
            dyn_ctrl1_reg <= i_reg_wdata;
         end
         if (i_reg_addr == sfs_pkg::SFS_REG_TREE_EN) begin
            tree_en_reg <= i_reg_wdata;
         end
      end
   end

   // Register reads answer one cycle later; other offsets read zero
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            sfs_pkg::SFS_REG_DYN_CTRL1: o_reg_rdata <= dyn_ctrl1_reg;
            sfs_pkg::SFS_REG_TREE_EN: o_reg_rdata <= tree_en_reg;
            default: o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // Rail judged on every fresh result; clearing the gate ends it at once
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         core_low_reg <= 1'b0;
      end else if (!core_low_gate) begin
         core_low_reg <= 1'b0;
      end else if (i_rail_valid) begin
         core_low_reg <= i_cpu_core_rail_input < i_core_low_limit;
      end
   end

   // Sticky status; a new low result wins over a clear in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_status_core_low <= 1'b0;
      end else if (core_low_gate && i_rail_valid &&
                   i_cpu_core_rail_input < i_core_low_limit) begin
         o_status_core_low <= 1'b1;
      end else if (i_status_clear) begin
         o_status_core_low <= 1'b0;
      end
   end

   // Alert follows the status bit only while its source is enabled
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_smbalert_n <= 1'b1;
      end else begin
         o_smbalert_n <= ~(o_status_core_low && i_alert_en);
      end
   end

   // Overtemp time accrues while the pin is low and the rail is up
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_overtemp_time <= sfs_pkg::SFS_OVERTEMP_TIME_RST;
         o_overtemp_watch <= 1'b0;
      end else begin
         o_overtemp_watch <= ~core_low_reg;
         // Held, not cleared, so the standby spell leaves no gap
         if (!core_low_reg && !overtemp_n_sync &&
             o_overtemp_time != 16'hffff) begin
            o_overtemp_time <= o_overtemp_time + 16'h0001;
         end
      end
   end

   // Turn-on temperature frozen while the rail is low
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fan_turn_on_temp <= sfs_pkg::SFS_TURN_ON_TEMP_RST;
      end else if (o_load_defaults) begin
         o_fan_turn_on_temp <= sfs_pkg::SFS_TURN_ON_TEMP_RST;
      end else if (i_fan_turn_on_temp_adj_valid && !core_low_reg) begin
         o_fan_turn_on_temp <= i_fan_turn_on_temp_adj_value;
      end
   end

   // Shutdown request passes only with the rail up
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_shutdown <= 1'b0;
      end else begin
         o_shutdown <= i_shutdown_req && !core_low_reg;
      end
   end

   // Power-on sequence: poll the rail, then count or wait for the host
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= sfs_pkg::SFS_ST_POLL;
      end else begin
         unique case (state_reg)
            sfs_pkg::SFS_ST_POLL: begin
               if (addr_hit) begin
                  state_reg <= sfs_pkg::SFS_ST_NORMAL;
               end else if (i_rail_valid) begin
                  state_reg <= (i_cpu_core_rail_input >=
                     sfs_pkg::SFS_RAIL_UP_CODE) ? sfs_pkg::SFS_ST_COUNT
                     : sfs_pkg::SFS_ST_WAIT_LOW;
               end
            end
            sfs_pkg::SFS_ST_WAIT_LOW: begin
               if (addr_hit) begin
                  state_reg <= sfs_pkg::SFS_ST_NORMAL;
               end else if (i_rail_valid && i_cpu_core_rail_input >=
                            sfs_pkg::SFS_RAIL_UP_CODE) begin
                  state_reg <= sfs_pkg::SFS_ST_COUNT;
               end
            end
            sfs_pkg::SFS_ST_COUNT: begin
               if (addr_hit) begin
                  state_reg <= sfs_pkg::SFS_ST_NORMAL;
               end else if (fs_cnt_reg == '0) begin
                  state_reg <= sfs_pkg::SFS_ST_FULL;
               end
            end
            sfs_pkg::SFS_ST_FULL: begin
               if (addr_hit) begin
                  state_reg <= sfs_pkg::SFS_ST_NORMAL;
               end
            end
            sfs_pkg::SFS_ST_NORMAL: begin
               state_reg <= sfs_pkg::SFS_ST_NORMAL;
            end
            default: begin
               state_reg <= sfs_pkg::SFS_ST_POLL; // Illegal code recovers
            end
         endcase
      end
   end

   // Countdown in system clocks, reloaded until counting starts
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fs_cnt_reg <= FS_LOAD;
      end else if (state_reg != sfs_pkg::SFS_ST_COUNT) begin
         fs_cnt_reg <= FS_LOAD;
      end else if (fs_cnt_reg != '0) begin
         fs_cnt_reg <= fs_cnt_reg - CW'(1);
      end
   end

   // Defaults load once, on the cycle the device enters normal work
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_load_defaults <= 1'b0;
         o_normal <= 1'b0;
         o_fans_full <= 1'b0;
      end else begin
         o_load_defaults <= addr_hit &&
            state_reg != sfs_pkg::SFS_ST_NORMAL;
         o_normal <= state_reg == sfs_pkg::SFS_ST_NORMAL;
         o_fans_full <= state_reg == sfs_pkg::SFS_ST_FULL;
      end
   end

   // One drive channel per output; each picks its own temperature channel
   for (genvar g = 0; g < sfs_pkg::SFS_NUM_PWM; g++) begin : g_out
      sfs_pwm_channel u_ch (
         .i_sys_clk(i_sys_clk),
         .i_reset_n(i_reset_n),
         .i_cfg(i_out_cfg[g]),
         .i_chan_duty(i_chan_duty),
         .i_run(o_normal),
         .o_active(ch_active[g]),
         .o_duty(o_duty[g*8 +: 8])
      );
   end

   // Pin drive: forced full speed overrides the loop
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pwm <= '0;
      end else begin
         for (int k = 0; k < sfs_pkg::SFS_NUM_PWM; k++) begin
            o_pwm[k] <= (o_fans_full | ch_active[k]) ^
               i_out_cfg[k].output_polarity_bit;
         end
      end
   end

   // Speed monitors on all four fans; a long period means a slow fan
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fan_fail <= '0;
      end else begin
         for (int f = 0; f < sfs_pkg::SFS_NUM_FANS; f++) begin
            o_fan_fail[f] <= o_normal &&
               i_tach_count[f] > i_tach_limit[f];
         end
      end
   end

   // Tree chain over the test pins; pins reach it only via two stages
   logic [TREE_PINS-1:0] tree_sync;
   sfs_sync #(.WIDTH(TREE_PINS)) u_tree_sync (
      .i_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_tree_pins),
      .o_sync(tree_sync)
   );

   always_comb begin
      tree_xnor = tree_sync[0];
      for (int t = 1; t < TREE_PINS; t++) begin
         tree_xnor = ~(tree_xnor ^ tree_sync[t]);
      end
   end

   // Output held low outside tree mode
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_tree_out <= 1'b0;
      end else begin
         o_tree_out <= tree_test_bit && tree_xnor;
      end
   end
endmodule

// *** verification/sfs_host_model.sv ***
/*
 Host and core rail converter model facing the supervisor.
 Assumes the bench calls its tasks; the link clock runs only in frames.
*/
`timescale 1ns/10ps
module sfs_host_model (
   // System clock
   input wire logic i_sys_clk,
   // Link side
   output logic o_link_clk,
   output logic o_link_addr_match,
   // Converter side
   output logic o_rail_valid,
   output logic [7:0] o_rail_code
);
   // Idle levels at time zero
   initial begin
      o_link_clk = 1'b0;
      o_link_addr_match = 1'b0;
      o_rail_valid = 1'b0;
      o_rail_code = 8'h00;
   end
   // Link clock periods; the clock stands still between frames
   task automatic cyc(input int n);
      repeat (n) begin
         #7.5 o_link_clk = 1'b1;
         #7.5 o_link_clk = 1'b0;
      end
   endtask
   // Frame addressing the device; slow stretches its preamble
   task automatic address(input int slow);
      #3;
      cyc(slow + 1);
      o_link_addr_match <= 1'b1;
      cyc(1);
      o_link_addr_match <= 1'b0;
      cyc(2);
   endtask
   // One conversion result, taken at the next system edge
   task automatic rail(input logic [7:0] code);
      @(posedge i_sys_clk);
      o_rail_valid <= 1'b1;
      o_rail_code <= code;
      @(posedge i_sys_clk);
      o_rail_valid <= 1'b0;
   endtask
endmodule

// *** verification/sfs_supervisor_properties.sv ***
/*
 Port checker of the supervisor.
 Assumes it is bound onto sfs_supervisor and alert enable is a level.
*/
`timescale 1ns/10ps
module sfs_supervisor_properties (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Causes
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_rail_valid,
   input wire logic [7:0] i_cpu_core_rail_input,
   input wire logic [7:0] i_core_low_limit,
   input wire logic i_alert_en,
   input wire logic i_shutdown_req,
   input wire sfs_pkg::sfs_out_cfg_t i_out_cfg [sfs_pkg::SFS_NUM_PWM],
   // Effects
   input wire logic o_status_core_low,
   input wire logic o_smbalert_n,
   input wire logic o_overtemp_watch,
   input wire logic [15:0] o_overtemp_time,
   input wire logic [7:0] o_fan_turn_on_temp,
   input wire logic o_shutdown,
   input wire logic o_tree_out,
   input wire logic [sfs_pkg::SFS_NUM_PWM-1:0] o_pwm,
   input wire logic o_fans_full,
   input wire logic o_load_defaults
);
   logic gate_reg; // Mirror of the low rail gate bit
   logic tree_reg; // Mirror of the tree bit
   logic under_reg; // Last result was under the limit
   logic low; // Gated low rail state
   logic [2:0] pol; // Polarity bits of the outputs
   assign low = under_reg && gate_reg;
   assign pol = {i_out_cfg[2].output_polarity_bit,
      i_out_cfg[1].output_polarity_bit, i_out_cfg[0].output_polarity_bit};
   // Register mirrors; defaults win over a write in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gate_reg <= 1'b0;
         tree_reg <= 1'b0;
      end else if (o_load_defaults) begin
         gate_reg <= 1'b0;
         tree_reg <= 1'b0;
      end else if (i_reg_wr) begin
         if (i_reg_addr == sfs_pkg::SFS_REG_DYN_CTRL1)
            gate_reg <= i_reg_wdata[sfs_pkg::SFS_CORE_LOW_GATE_POS];
         if (i_reg_addr == sfs_pkg::SFS_REG_TREE_EN)
            tree_reg <= i_reg_wdata[sfs_pkg::SFS_TREE_BIT_POS];
      end
   end
   // Judged per conversion; gate off drops it at once
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         under_reg <= 1'b0;
      else if (!gate_reg)
         under_reg <= 1'b0;
      else if (i_rail_valid)
         under_reg <= i_cpu_core_rail_input < i_core_low_limit;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // A gated conversion under the limit
   sequence s_low_hit;
      i_rail_valid && gate_reg && i_cpu_core_rail_input < i_core_low_limit;
   endsequence
   a_status_set: assert property (s_low_hit |=> o_status_core_low)
      else $error("status not set on low rail");
   a_alert_low: assert property (
      $rose(o_status_core_low) && i_alert_en |=> !o_smbalert_n)
      else $error("alert not raised");
   a_watch_off: assert property (s_low_hit |-> ##2 !o_overtemp_watch)
      else $error("overtemp watch kept on low rail");
   a_timer_hold: assert property (
      !o_overtemp_watch [*3] |-> $stable(o_overtemp_time))
      else $error("overtemp timer moved while not watching");
   a_fan_turn_on_temp_frozen: assert property (
      $past(low) && !$past(o_load_defaults) |-> $stable(o_fan_turn_on_temp))
      else $error("turn-on temperature moved on low rail");
   a_no_shutdown: assert property (low |=> !o_shutdown)
      else $error("shutdown entered on low rail");
   a_shutdown_back: assert property (!low && i_shutdown_req |=> o_shutdown)
      else $error("shutdown not resumed");
   a_tree_off: assert property (!tree_reg |=> !o_tree_out)
      else $error("tree output active with bit clear");
   a_full_drive: assert property (
      o_fans_full && $past(o_fans_full) |-> o_pwm == ~pol)
      else $error("full drive ignores polarity");
endmodule

bind sfs_supervisor sfs_supervisor_properties chk (.*);

// *** verification/tb.sv ***
/*
 Self-checking bench of the supervisor with the host model.
 Assumes a shortened fail-safe count and fixed drive settings.
*/
`timescale 1ns/10ps
module tb;
   localparam int FS = 200; // Short fail-safe count
   localparam logic [2:0] POL = 3'b101; // Output polarity bits
   logic i_sys_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_link_clk, i_link_addr_match, i_rail_valid; // From host
   logic [7:0] i_cpu_core_rail_input;
   logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_status_clear = 1'b0;
   logic i_alert_en = 1'b1, i_overtemp_pin_n = 1'b1;
   logic i_fan_turn_on_temp_adj_valid = 1'b0, i_shutdown_req = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
   logic [7:0] i_fan_turn_on_temp_adj_value = 8'h00, i_core_low_limit = 8'h80;
   logic [7:0] i_tree_pins = 8'h00, o_reg_rdata, o_fan_turn_on_temp;
   logic [7:0] i_chan_duty [3] = '{8'h10, 8'h55, 8'ha0};
   sfs_pkg::sfs_out_cfg_t i_out_cfg [3] = '{'{1'b1, 2'h0, 8'h40, 4'h0},
      '{1'b0, 2'h2, 8'h00, 4'h0}, '{1'b1, 2'h1, 8'h00, 4'h0}};
   logic [15:0] i_tach_count [4] = '{default: 16'h0050};
   logic [15:0] i_tach_limit [4] = '{default: 16'h0100};
   logic o_status_core_low, o_smbalert_n, o_overtemp_watch, o_tree_out;
   logic o_shutdown, o_fans_full, o_load_defaults, o_normal;
   logic [15:0] o_overtemp_time, held;
   logic [3:0] o_fan_fail;
   logic [2:0] o_pwm;
   logic [23:0] o_duty;
   int failures = 0, tests_run = 0, loads = 0;

   always #50 i_sys_clk = ~i_sys_clk;
   // Default loads, counted at a settled point
   always @(negedge i_sys_clk) begin
      if (o_load_defaults) loads++;
   end

   sfs_host_model host (.i_sys_clk, .o_link_clk(i_link_clk),
      .o_link_addr_match(i_link_addr_match), .o_rail_valid(i_rail_valid),
      .o_rail_code(i_cpu_core_rail_input));
   sfs_supervisor #(.FAILSAFE_CYC(FS)) dut (.*);

   // Rising edges for driving
   task step(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // Edges, then a settled point to sample
   task look(input int n);
      step(n);
      @(negedge i_sys_clk);
   endtask
   task chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      step(1);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      step(1);
      i_reg_wr <= 1'b0;
   endtask
   // Read data lands one cycle after the read edge
   task rd(input logic [7:0] a, input logic [7:0] exp);
      step(1);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      step(1);
      i_reg_rd <= 1'b0;
      look(0);
      chk(o_reg_rdata, exp);
   endtask
   task adj(input logic [7:0] v);
      step(1);
      i_fan_turn_on_temp_adj_valid <= 1'b1;
      i_fan_turn_on_temp_adj_value <= v;
      step(1);
      i_fan_turn_on_temp_adj_valid <= 1'b0;
   endtask
   // Expected chain of XNOR gates over the pins
   function logic xchain(input logic [7:0] p);
      logic r;
      r = p[0];
      for (int i = 1; i < 8; i++) r = ~(r ^ p[i]);
      return r;
   endfunction
   // Reset, first conversion, then a host access early or late
   task pu(input logic [7:0] code, input logic early, input logic full);
      step(1);
      i_reset_n <= 1'b0;
      host.cyc(2);
      step(5);
      i_reset_n <= 1'b1;
      host.rail(code);
      look(FS - 20);
      chk(o_fans_full, 1'b0);
      if (!early) begin
         look(45);
         chk(o_fans_full, full);
         if (full) chk(o_pwm, 3'(~POL));
      end
      host.address(early ? 0 : 4);
      look(8);
      chk({o_normal, o_fans_full}, 2'b10);
      look(FS);
      chk(o_fans_full, 1'b0);
      $display("power-up test done");
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial begin
      pu(8'h20, 1'b0, 1'b0);
      pu(8'hc0, 1'b1, 1'b0);
      pu(8'hc0, 1'b0, 1'b1);
      rd(sfs_pkg::SFS_REG_DYN_CTRL1, sfs_pkg::SFS_DYN_CTRL1_RST);
      rd(sfs_pkg::SFS_REG_TREE_EN, sfs_pkg::SFS_TREE_EN_RST);
      wr(8'h37, 8'hff);
      rd(8'h37, 8'h00);
      wr(sfs_pkg::SFS_REG_DYN_CTRL1, 8'h02);
      rd(sfs_pkg::SFS_REG_DYN_CTRL1, 8'h02);
      step(1);
      i_shutdown_req <= 1'b1;
      i_overtemp_pin_n <= 1'b0;
      look(20);
      chk({o_overtemp_watch, o_shutdown}, 2'b11);
      host.rail(8'h10);
      look(2);
      chk({o_status_core_low, o_smbalert_n}, 2'b10);
      chk({o_overtemp_watch, o_shutdown}, 2'b00);
      held = o_overtemp_time;
      chk(held > 16'h0010, 1'b1);
      adj(8'h33);
      look(20);
      chk(o_overtemp_time, held);
      chk(o_fan_turn_on_temp, sfs_pkg::SFS_TURN_ON_TEMP_RST);
      host.rail(8'h90);
      look(3);
      chk({o_overtemp_watch, o_shutdown, o_status_core_low}, 3'h7);
      adj(8'h33);
      look(2);
      chk(o_fan_turn_on_temp, 8'h33);
      step(1);
      i_status_clear <= 1'b1;
      step(1);
      i_status_clear <= 1'b0;
      wr(sfs_pkg::SFS_REG_DYN_CTRL1, 8'h00);
      host.rail(8'h10);
      look(2);
      chk({o_status_core_low, o_smbalert_n}, 2'b01);
      $display("low rail test done");
      wr(sfs_pkg::SFS_REG_TREE_EN, 8'h01);
      for (int k = 0; k < 4; k++) begin
         step(1);
         i_tree_pins <= 8'(k * 8'h25 + 8'h01);
         look(5);
         chk(o_tree_out, xchain(i_tree_pins));
      end
      wr(sfs_pkg::SFS_REG_TREE_EN, 8'h00);
      look(3);
      chk(o_tree_out, 1'b0);
      chk(o_duty, {8'h55, 8'ha0, 8'h40});
      step(1);
      i_tach_count[3] <= 16'h0200;
      look(3);
      chk(o_fan_fail, 4'h8);
      chk(24'(loads), 24'h000003);
      $display("drive test done");
      end_sim;
   end

   // Watchdog well beyond the expected run
   initial begin
      #2000000;
      failures++;
      $display("wrong value at %0t: watchdog", $time);
      end_sim;
   end
endmodule
